// [bscc_pkg.sv]
package bscc_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_ACC = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_PC = 8'h10;
    localparam logic [7:0] ADDR_UPPER = 8'h14;
    localparam logic [7:0] ADDR_STACK = 8'h18;
    localparam logic [7:0] ADDR_WDOG = 8'h1c;
    localparam logic [7:0] ADDR_FILE_SEL = 8'h20;
    localparam logic [7:0] ADDR_FILE_DATA = 8'h24;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_STEP_BIT = 0;
    localparam int STATUS_ZERO_BIT = 2;
    localparam int STATUS_SLEEP_BIT = 3;
    localparam int STATUS_EXPIRY_BIT = 4;
    localparam int STATUS_BUSY_BIT = 8;
    localparam int STATUS_BANK_LO = 5;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam int UPPER_LO = 3;
    localparam int UPPER_HI = 4;
    localparam int DEST_BIT = 7;
    localparam int STACK_DEPTH = 8;
    localparam int FILE_WORDS = 256;

    // ----------------------------------------------------------------
    // opcodes, 14-bit instruction word
    // ----------------------------------------------------------------
    localparam logic [13:0] OP_KICK = 14'h0064;
    localparam logic [13:0] OP_CLRACC = 14'h0100;
    localparam logic [6:0] OP_CLRACC_MASK = 7'h7f;
    localparam logic [6:0] OP_CLEAR_FILE_REGISTER = 7'h03;
    localparam logic [5:0] OP_INVERT_REGISTER = 6'h09;
    localparam logic [5:0] OP_DECREMENT_REGISTER = 6'h03;
    localparam logic [3:0] OP_SKIPSET = 4'h7;
    localparam logic [2:0] OP_CALL = 3'h4;

    // core sequencing states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_NOP = 3'b100
    } bscc_state_t;
endpackage

// [bscc_filemem.sv]
`timescale 1ns/1ps
// data memory, registered read, one write port
module bscc_filemem (
    input wire logic aclk, // clock
    input wire logic we, // write strobe
    input wire logic [7:0] waddr, // write address
    input wire logic [7:0] wdata, // write data
    input wire logic [7:0] raddr, // read address
    output logic [7:0] rdata // registered read data
);
    logic [7:0] mem [0:bscc_pkg::FILE_WORDS-1];

    // -------------------------------------------------------------
    // storage; no reset, contents are software's job
    // -------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // bscc_filemem

// [bscc_stack.sv]
`timescale 1ns/1ps
// circular return stack, eight deep, wraps silently on overflow
module bscc_stack (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic push, // push strobe
    input wire logic [12:0] push_data, // return address
    output logic [12:0] stack_top // current top entry
);
    logic [12:0] ent_reg [0:bscc_pkg::STACK_DEPTH-1];
    logic [2:0] ptr_reg;
    logic [2:0] ptr_next;

    // pointer advance on push
    always_comb begin
        ptr_next = push ? ptr_reg + 3'h1 : ptr_reg;
    end

    // -------------------------------------------------------------
    // entries, one per slot
    // -------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < bscc_pkg::STACK_DEPTH; gi++) begin : g_ent
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ent_reg[gi] <= 13'h0000;
                end else if (push && ptr_next == 3'(gi)) begin
                    ent_reg[gi] <= push_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_reg <= 3'h0;
            stack_top <= 13'h0000;
        end else begin
            ptr_reg <= ptr_next;
            stack_top <= push ? push_data : ent_reg[ptr_reg]; // entry under the pointer
        end
    end
endmodule // bscc_stack

// [bscc_core.sv]
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module bscc_core (
    input wire logic aclk, // 100 MHz clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic wdog_clear // one-cycle pulse: watchdog counter cleared
);
    // -------------------------------------------------------------
    // architectural state
    // -------------------------------------------------------------
    bscc_pkg::bscc_state_t state_reg, state_next;
    logic [13:0] instr_reg, instr_next;
    logic [7:0] acc_reg, acc_next;
    logic [7:0] status_reg, status_next;
    logic [12:0] pc_reg, pc_next;
    logic [7:0] upper_reg, upper_next;
    logic [7:0] wdog_reg, wdog_next;
    logic [7:0] fsel_reg, fsel_next;
    logic wclr_next;

    // bus state
    logic aw_ok_reg, aw_ok_next, w_ok_reg, w_ok_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next, bresp_err_reg, bresp_err_next;
    logic rvalid_reg, rvalid_next, rerr_reg, rerr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rpend_reg, rpend_next;
    logic [7:0] rd_addr_reg;

    // memory and stack ports
    logic mem_we;
    logic [7:0] mem_waddr, mem_wdata, mem_raddr, mem_rdata;
    logic push;
    logic [12:0] stack_top;

    // -------------------------------------------------------------
    // decode of the held instruction word
    // -------------------------------------------------------------
    logic [7:0] faddr;
    logic dest_file, is_kick, is_clracc, is_clear_file_register, is_invert_register, is_decrement_register, is_skip, is_call;
    logic bit_set;
    logic [7:0] result;
    assign faddr = {status_reg[bscc_pkg::STATUS_BANK_LO], instr_reg[6:0]};
    assign dest_file = instr_reg[bscc_pkg::DEST_BIT];
    assign is_kick = instr_reg == bscc_pkg::OP_KICK;
    assign is_clracc = instr_reg[13:7] == bscc_pkg::OP_CLRACC[13:7];
    assign is_clear_file_register = instr_reg[13:7] == bscc_pkg::OP_CLEAR_FILE_REGISTER;
    assign is_invert_register = instr_reg[13:8] == bscc_pkg::OP_INVERT_REGISTER;
    assign is_decrement_register = instr_reg[13:8] == bscc_pkg::OP_DECREMENT_REGISTER;
    assign is_skip = instr_reg[13:10] == bscc_pkg::OP_SKIPSET;
    assign is_call = instr_reg[13:11] == bscc_pkg::OP_CALL;
    assign bit_set = mem_rdata[instr_reg[9:7]];
    assign result = is_invert_register ? ~mem_rdata : mem_rdata - 8'h01;

    // -------------------------------------------------------------
    // bus address capture and response
    // -------------------------------------------------------------
    logic wr_fire, rd_fire, wr_busy;
    assign wr_fire = aw_ok_reg && w_ok_reg && !bvalid_reg;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign wr_busy = state_reg != bscc_pkg::ST_IDLE;

    // memory muxing: the core owns the read port while executing
    always_comb begin
        mem_raddr = wr_busy ? faddr : (rd_fire ? fsel_reg : faddr);
        mem_we = 1'b0;
        mem_waddr = faddr;
        mem_wdata = 8'h00;
        if (state_reg == bscc_pkg::ST_EXEC
                && (is_clear_file_register || ((is_invert_register || is_decrement_register) && dest_file))) begin
            mem_we = 1'b1;
            mem_wdata = is_clear_file_register ? 8'h00 : result;
        end else if (wr_fire && !wr_busy && awaddr_reg == bscc_pkg::ADDR_FILE_DATA
                && wstrb_reg[0]) begin
            mem_we = 1'b1;
            mem_waddr = fsel_reg;
            mem_wdata = wdata_reg[7:0];
        end
    end

    // -------------------------------------------------------------
    // execution sequencing and architectural updates
    // -------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        instr_next = instr_reg;
        acc_next = acc_reg;
        status_next = status_reg;
        pc_next = pc_reg;
        upper_next = upper_reg;
        wdog_next = wdog_reg;
        fsel_next = fsel_reg;
        wclr_next = 1'b0;
        push = 1'b0;
        unique case (state_reg)
            // one cycle to fetch the operand from the registered memory
            bscc_pkg::ST_IDLE: begin
                if (wr_fire && awaddr_reg == bscc_pkg::ADDR_CTRL && wstrb_reg[0]
                        && wdata_reg[bscc_pkg::CTRL_STEP_BIT]) begin
                    state_next = bscc_pkg::ST_EXEC;
                end
            end
            bscc_pkg::ST_EXEC: begin
                state_next = bscc_pkg::ST_IDLE;
                pc_next = pc_reg + 13'h0001;
                if (is_kick) begin
                    wdog_next = 8'h00;
                    wclr_next = 1'b1;
                    status_next[bscc_pkg::STATUS_EXPIRY_BIT] = 1'b1;
                    status_next[bscc_pkg::STATUS_SLEEP_BIT] = 1'b1;
                end else if (is_clracc) begin
                    acc_next = 8'h00;
                    status_next[bscc_pkg::STATUS_ZERO_BIT] = 1'b1;
                end else if (is_clear_file_register) begin
                    status_next[bscc_pkg::STATUS_ZERO_BIT] = 1'b1;
                end else if (is_invert_register || is_decrement_register) begin
                    if (!dest_file) begin
                        acc_next = result;
                    end
                    status_next[bscc_pkg::STATUS_ZERO_BIT] = result == 8'h00;
                end else if (is_skip) begin
                    if (bit_set) begin
                        pc_next = pc_reg + 13'h0002;
                        state_next = bscc_pkg::ST_NOP;
                    end
                end else if (is_call) begin
                    push = 1'b1;
                    pc_next = {upper_reg[bscc_pkg::UPPER_HI:bscc_pkg::UPPER_LO],
                        instr_reg[10:0]};
                    state_next = bscc_pkg::ST_NOP;
                end
            end
            // second cycle does nothing but pass time; flags untouched
            bscc_pkg::ST_NOP: begin
                state_next = bscc_pkg::ST_IDLE;
            end
            default: begin
                state_next = bscc_pkg::ST_IDLE;
            end
        endcase
        // software writes only land while the core is idle
        if (wr_fire && !wr_busy) begin
            unique case (awaddr_reg)
                bscc_pkg::ADDR_INSTR: instr_next = wdata_reg[13:0];
                bscc_pkg::ADDR_ACC: acc_next = wdata_reg[7:0];
                bscc_pkg::ADDR_STATUS: status_next = wdata_reg[7:0];
                bscc_pkg::ADDR_PC: pc_next = wdata_reg[12:0];
                bscc_pkg::ADDR_UPPER: upper_next = wdata_reg[7:0];
                bscc_pkg::ADDR_WDOG: wdog_next = wdata_reg[7:0];
                bscc_pkg::ADDR_FILE_SEL: fsel_next = wdata_reg[7:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // axi4-lite channel handshakes
    // -------------------------------------------------------------
    logic wr_map_ok, rd_map_ok;
    assign wr_map_ok = awaddr_reg <= bscc_pkg::ADDR_FILE_DATA && awaddr_reg[1:0] == 2'h0;
    assign rd_map_ok = s_axi_araddr <= bscc_pkg::ADDR_FILE_DATA && s_axi_araddr[1:0] == 2'h0;
    always_comb begin
        aw_ok_next = aw_ok_reg;
        w_ok_next = w_ok_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_err_next = bresp_err_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_ok_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        // write waits out an executing instruction so state stays coherent
        if (wr_fire && !wr_busy) begin
            aw_ok_next = 1'b0;
            w_ok_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_err_next = !wr_map_ok;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        rpend_next = rd_fire;
        rvalid_next = rvalid_reg;
        rerr_next = rerr_reg;
        rdata_next = rdata_reg;
        if (rd_fire) begin
            rerr_next = !rd_map_ok;
            unique case (s_axi_araddr)
                bscc_pkg::ADDR_INSTR: rdata_next = {18'h00000, instr_reg};
                bscc_pkg::ADDR_ACC: rdata_next = {24'h000000, acc_reg};
                bscc_pkg::ADDR_STATUS: rdata_next = {23'h000000, wr_busy, status_reg};
                bscc_pkg::ADDR_PC: rdata_next = {19'h00000, pc_reg};
                bscc_pkg::ADDR_UPPER: rdata_next = {24'h000000, upper_reg};
                bscc_pkg::ADDR_STACK: rdata_next = {19'h00000, stack_top};
                bscc_pkg::ADDR_WDOG: rdata_next = {24'h000000, wdog_reg};
                bscc_pkg::ADDR_FILE_SEL: rdata_next = {24'h000000, fsel_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        // file data comes from the memory one cycle later
        if (rpend_reg) begin
            rvalid_next = 1'b1;
            if (!rerr_reg && rd_addr_reg == bscc_pkg::ADDR_FILE_DATA) begin
                rdata_next = {24'h000000, mem_rdata};
            end
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= bscc_pkg::ST_IDLE;
            instr_reg <= 14'h0000;
            acc_reg <= 8'h00;
            status_reg <= bscc_pkg::STATUS_RESET;
            pc_reg <= bscc_pkg::PC_RESET;
            upper_reg <= 8'h00;
            wdog_reg <= 8'h00;
            fsel_reg <= 8'h00;
            wdog_clear <= 1'b0;
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_err_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rerr_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rpend_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            state_reg <= state_next;
            instr_reg <= instr_next;
            acc_reg <= acc_next;
            status_reg <= status_next;
            pc_reg <= pc_next;
            upper_reg <= upper_next;
            wdog_reg <= wdog_next;
            fsel_reg <= fsel_next;
            wdog_clear <= wclr_next;
            aw_ok_reg <= aw_ok_next;
            w_ok_reg <= w_ok_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_err_reg <= bresp_err_next;
            rvalid_reg <= rvalid_next;
            rerr_reg <= rerr_next;
            rdata_reg <= rdata_next;
            rpend_reg <= rpend_next;
            rd_addr_reg <= rd_fire ? s_axi_araddr : rd_addr_reg;
            // ready is a one-cycle pulse, re-armed once the slot empties
            s_axi_awready <= !aw_ok_next && !s_axi_awready && s_axi_awvalid && !bvalid_next;
            s_axi_wready <= !w_ok_next && !s_axi_wready && s_axi_wvalid && !bvalid_next;
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !rpend_next && !rvalid_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = {bresp_err_reg, 1'b0}; // slverr or okay, no gate after the flop
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = {rerr_reg, 1'b0};

    // -------------------------------------------------------------
    // data memory and return stack
    // -------------------------------------------------------------
    bscc_filemem u_mem (
        .aclk(aclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    bscc_stack u_stack (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(push),
        .push_data(pc_reg + 13'h0001),
        .stack_top(stack_top)
    );
endmodule // bscc_core

// [bscc_asserts.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus handshake and watchdog strobe checks
// ------------------------------------------------------------
module bscc_asserts (
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic [1:0] s_axi_rresp, // r resp
    input wire logic wdog_clear // watchdog clear strobe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a stuck strobe would pin the counter at zero
    property p_wdog_pulse; wdog_clear |=> !wdog_clear; endproperty
    a_wdog_pulse: assert property (p_wdog_pulse)
        else $error("watchdog clear longer than one cycle");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped early");
    property p_rlat; s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_awpulse; s_axi_awready |=> !s_axi_awready; endproperty
    a_awpulse: assert property (p_awpulse) else $error("awready not a pulse");
    property p_arpulse; s_axi_arready |=> !s_axi_arready; endproperty
    a_arpulse: assert property (p_arpulse) else $error("arready not a pulse");
    property p_bresp; s_axi_bvalid |-> !s_axi_bresp[0]; endproperty
    a_bresp: assert property (p_bresp) else $error("write response code illegal");
    // refused reads must not leak stale data
    property p_rzero; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
    a_rzero: assert property (p_rzero) else $error("refused read returned data");
    c_kick: cover property (wdog_clear);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // bscc_asserts

bind bscc_core bscc_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .wdog_clear(wdog_clear));

// [test_bit_skip_call_clear_ops.sv]
`timescale 1ns/1ps
module test_bit_skip_call_clear_ops;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdog_clear;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    int errors = 0, n_compared = 0, n_kick = 0;

    bscc_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wdog_clear(wdog_clear));

    // 100 MHz clock
    always #5 aclk = ~aclk;
    // count watchdog strobes to catch doubled pulses
    always @(posedge aclk) begin
        if (wdog_clear === 1'b1) n_kick <= n_kick + 1;
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // step one instruction, poll busy with a bound so a hang shows as mismatches
    task automatic run(input logic [13:0] op);
        wr(bscc_pkg::ADDR_INSTR, {18'h0, op});
        wr(bscc_pkg::ADDR_CTRL, 32'h1);
        for (int i = 0; i < 20; i++) begin
            rdr(bscc_pkg::ADDR_STATUS);
            if (rd[bscc_pkg::STATUS_BUSY_BIT] === 1'b0) break;
        end
    endtask

    task automatic fset(input logic [7:0] f, input logic [7:0] v);
        wr(bscc_pkg::ADDR_FILE_SEL, {24'h0, f});
        wr(bscc_pkg::ADDR_FILE_DATA, {24'h0, v});
    endtask

    task automatic fchk(input logic [7:0] f, input logic [7:0] v);
        wr(bscc_pkg::ADDR_FILE_SEL, {24'h0, f});
        rdr(bscc_pkg::ADDR_FILE_DATA);
        chk("file", {24'h0, rd[7:0]}, {24'h0, v});
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] v);
        rdr(a);
        chk(what, rd & m, v);
    endtask

    task automatic t_reset;
        rchk("status", bscc_pkg::ADDR_STATUS, 32'hff, 32'(bscc_pkg::STATUS_RESET));
        rchk("pc", bscc_pkg::ADDR_PC, 32'h1fff, {19'h0, bscc_pkg::PC_RESET});
        rdr(8'h40);
        chk("unmapped resp", {30'h0, resp}, 32'h2);
        chk("unmapped data", rd, 32'h0);
        wr(8'h40, 32'h0);
        chk("unmapped bresp", {30'h0, resp}, 32'h2);
        $display("test reset done");
    endtask

    task automatic t_clear;
        fset(8'h21, 8'h5a);
        wr(bscc_pkg::ADDR_STATUS, 32'h18);
        run({bscc_pkg::OP_CLEAR_FILE_REGISTER, 7'h21});
        fchk(8'h21, 8'h00);
        rchk("zero", bscc_pkg::ADDR_STATUS, 32'h4, 32'h4);
        wr(bscc_pkg::ADDR_ACC, 32'h33);
        wr(bscc_pkg::ADDR_STATUS, 32'h18);
        run(bscc_pkg::OP_CLRACC);
        rchk("acc", bscc_pkg::ADDR_ACC, 32'hff, 32'h0);
        rchk("zero", bscc_pkg::ADDR_STATUS, 32'h4, 32'h4);
        $display("test clear done");
    endtask

    // both destinations, zero flag driven both ways
    task automatic t_alu;
        fset(8'h10, 8'ha5);
        run({bscc_pkg::OP_INVERT_REGISTER, 1'b0, 7'h10});
        rchk("acc", bscc_pkg::ADDR_ACC, 32'hff, 32'h5a);
        fchk(8'h10, 8'ha5);
        fset(8'h11, 8'hff);
        run({bscc_pkg::OP_INVERT_REGISTER, 1'b1, 7'h11});
        fchk(8'h11, 8'h00);
        rchk("zero", bscc_pkg::ADDR_STATUS, 32'h4, 32'h4);
        fset(8'h12, 8'h01);
        wr(bscc_pkg::ADDR_STATUS, 32'h18);
        run({bscc_pkg::OP_DECREMENT_REGISTER, 1'b0, 7'h12});
        rchk("acc", bscc_pkg::ADDR_ACC, 32'hff, 32'h0);
        rchk("zero", bscc_pkg::ADDR_STATUS, 32'h4, 32'h4);
        fset(8'h13, 8'h00);
        run({bscc_pkg::OP_DECREMENT_REGISTER, 1'b1, 7'h13});
        fchk(8'h13, 8'hff);
        rchk("zero", bscc_pkg::ADDR_STATUS, 32'h4, 32'h0);
        $display("test alu done");
    endtask

    task automatic t_flow;
        fset(8'h20, 8'h80);
        wr(bscc_pkg::ADDR_STATUS, 32'h1c);
        wr(bscc_pkg::ADDR_PC, 32'h10);
        run({bscc_pkg::OP_SKIPSET, 3'd7, 7'h20});
        rchk("pc", bscc_pkg::ADDR_PC, 32'h1fff, 32'h12);
        run({bscc_pkg::OP_SKIPSET, 3'd0, 7'h20});
        rchk("pc", bscc_pkg::ADDR_PC, 32'h1fff, 32'h13);
        wr(bscc_pkg::ADDR_PC, 32'h123);
        wr(bscc_pkg::ADDR_UPPER, 32'h18);
        run({bscc_pkg::OP_CALL, 11'h7ff});
        rchk("pc", bscc_pkg::ADDR_PC, 32'h1fff, 32'h1fff);
        rchk("stack", bscc_pkg::ADDR_STACK, 32'h1fff, 32'h124);
        wr(bscc_pkg::ADDR_UPPER, 32'h08);
        run({bscc_pkg::OP_CALL, 11'h000});
        rchk("pc", bscc_pkg::ADDR_PC, 32'h1fff, 32'h800);
        rchk("stack", bscc_pkg::ADDR_STACK, 32'h1fff, 32'h0);
        rchk("flags", bscc_pkg::ADDR_STATUS, 32'hff, 32'h1c);
        $display("test flow done");
    endtask

    task automatic t_kick;
        int k0;
        wr(bscc_pkg::ADDR_STATUS, 32'h0);
        wr(bscc_pkg::ADDR_WDOG, 32'h55);
        k0 = n_kick;
        run(bscc_pkg::OP_KICK);
        rchk("wdog", bscc_pkg::ADDR_WDOG, 32'hff, 32'h0);
        chk("strobes", n_kick - k0, 32'h1);
        rchk("flags", bscc_pkg::ADDR_STATUS, 32'h18, 32'h18);
        $display("test kick done");
    endtask

    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // about 500 cycles expected, so 30000 is ample
    initial begin
        #300000;
        errors++;
        stop_test;
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_clear;
        t_alu;
        t_flow;
        t_kick;
        stop_test;
    end
endmodule // test_bit_skip_call_clear_ops
